// file: shared/owc_pkg.sv
// Purpose: Shared constants and types for the oscillator warm-up counter.
// Assumes: Control bytes arrive as plain ports; no register bus.
// Notes:   Field positions and codes of the two timer control bytes.
package owc_pkg;

    // Lower timer control byte fields
    localparam int       LTC_MODE_LSB     = 0;
    localparam int       LTC_SRC_LSB      = 4;
    localparam int       LTC_FLOP_BIT     = 7;
    localparam logic [2:0] LTC_MODE_CASCADE = 3'h3;
    localparam logic [2:0] LTC_SRC_LOW      = 3'h4;
    localparam logic [2:0] LTC_SRC_HIGH     = 3'h6;

    // Upper timer control byte fields
    localparam int       UTC_MODE_LSB     = 0;
    localparam int       UTC_START_BIT    = 3;
    localparam int       UTC_FLOP_BIT     = 7;
    localparam logic [2:0] UTC_MODE_WARM    = 3'h5;

    // Values after reset
    localparam logic [15:0] CNT_RESET  = 16'h0000;
    localparam logic        FLAG_RESET = 1'b0;

    // One step of the high period byte is this many source ticks
    localparam int       STEP_TICKS       = 256;
    // Nominal source rates and the spans they give (ns)
    localparam longint   LOW_FREQ_HZ      = 32768;
    localparam longint   HIGH_FREQ_HZ     = 16000000;
    localparam longint   LOW_MIN_NS       = (longint'(STEP_TICKS) * 1000000000) / LOW_FREQ_HZ;
    localparam longint   HIGH_MIN_NS      = (longint'(STEP_TICKS) * 1000000000) / HIGH_FREQ_HZ;

    // Control bundle written by software
    typedef struct packed {
        logic [7:0] lower_timer_control;
        logic [7:0] upper_timer_control;
        logic [7:0] period_high_byte;
        logic [7:0] period_low_byte;
    } owc_ctrl_t;

    // Sequencer states, Gray coded along idle -> run -> hit
    typedef enum logic [1:0] {
        OWC_IDLE = 2'h0,
        OWC_RUN  = 2'h1,
        OWC_HIT  = 2'h3
    } owc_state_t;

endpackage

// file: design/owc_edge.sv
// Purpose: Rising-edge detector for one oscillator level.
// Assumes: Oscillator level is synchronous to clock.
// Notes:   Pulse is one clock cycle wide per source rising edge.
`timescale 1ns/1ns
`default_nettype none
module owc_edge (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst_b,
    // Source level and edge pulse
    input  wire logic level,
    output logic      rise
);
    import owc_pkg::*;

    logic prev_reg;
    logic prev_next;

    // Remember the last level
    always_comb begin
        prev_next = level;
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            prev_reg <= FLAG_RESET;
        end else begin
            prev_reg <= prev_next;
        end
    end

    // Edge pulse
    assign rise = level & ~prev_reg;
endmodule
`default_nettype wire

// file: design/owc_counter.sv
// Purpose: 16-bit warm-up counter built from two cascaded 8-bit timers.
// Assumes: Oscillator levels are synchronous inputs; software keeps its own sequence.
// Notes:   Only the high period byte sets the span; the low byte is ignored.
//
// Operation
// - Started counter counts; match clears it, raises irq.
// - Slow warm-up spans 7.81 ms to 1.99 s.
// - Fast warm-up spans 16 us to 4.08 ms.
// - Lower control 43H selects slow source, cascade.
// - Lower control 63H selects fast source, cascade.
// - Upper control 05H selects warm-up mode, flop clear.
// - Match compares only the high period byte.
// - Two 8-bit timers cascade into 16 bits.
`timescale 1ns/1ns
`default_nettype none
module owc_counter (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rst_b,
    // Oscillator levels
    input  wire logic              low_freq_clock,
    input  wire logic              high_freq_clock,
    // Software control bundle
    input  wire owc_pkg::owc_ctrl_t ctrl,
    // Status and event
    output logic [15:0]            count_value,
    output logic                   timer_match_irq,
    output logic                   warm_active,
    output logic                   upper_flop_out,
    output logic                   lower_flop_out
);
    import owc_pkg::*;

    logic        low_rise;
    logic        high_rise;
    logic [2:0]  src_sel;
    logic        mode_ok;
    logic        run;
    logic        src_tick;
    logic [15:0] inc;
    logic        hit;

    owc_state_t  state_reg;
    owc_state_t  state_next;
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic        irq_reg;
    logic        irq_next;
    logic        warm_reg;
    logic        warm_next;
    logic        uflop_reg;
    logic        uflop_next;
    logic        lflop_reg;
    logic        lflop_next;

    // Edge finders for the two sources
    owc_edge u_low_edge (
        .clock (clock),
        .rst_b (rst_b),
        .level (low_freq_clock),
        .rise  (low_rise)
    );
    owc_edge u_high_edge (
        .clock (clock),
        .rst_b (rst_b),
        .level (high_freq_clock),
        .rise  (high_rise)
    );

    // Mode decode of both control bytes
    assign src_sel = ctrl.lower_timer_control[LTC_SRC_LSB +: 3];
    assign mode_ok = (ctrl.lower_timer_control[LTC_MODE_LSB +: 3] == LTC_MODE_CASCADE) &&
                     (ctrl.upper_timer_control[UTC_MODE_LSB +: 3] == UTC_MODE_WARM) &&
                     ((src_sel == LTC_SRC_LOW) || (src_sel == LTC_SRC_HIGH));
    assign run     = mode_ok && ctrl.upper_timer_control[UTC_START_BIT];

    // Count source follows the lower control byte
    assign src_tick = (src_sel == LTC_SRC_LOW) ? low_rise : high_rise;

    // Cascade: carry from the low byte into the high byte
    assign inc = 16'(cnt_reg + 16'h0001);
    // Only the upper byte is compared, taken at the carry into it, so the span is a
    // multiple of 256 ticks; a zero high byte waits for the full 16-bit wrap
    assign hit = run && src_tick && (inc[15:8] == ctrl.period_high_byte) && (inc[7:0] == 8'h00);

    // Sequencer and counter next values
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        irq_next   = 1'b0;
        unique case (state_reg)
            OWC_IDLE: begin
                cnt_next = CNT_RESET;
                if (run) begin
                    state_next = OWC_RUN;
                end
            end
            OWC_RUN, OWC_HIT: begin
                if (!run) begin
                    // Stopping also clears, so a restart measures a full span
                    state_next = OWC_IDLE;
                    cnt_next   = CNT_RESET;
                end else if (hit) begin
                    state_next = OWC_HIT;
                    cnt_next   = CNT_RESET;
                    irq_next   = 1'b1;
                end else begin
                    state_next = OWC_RUN;
                    if (src_tick) begin
                        cnt_next = inc;
                    end
                end
            end
            default: begin
                state_next = OWC_IDLE;
                cnt_next   = CNT_RESET;
            end
        endcase
        // Busy flag registered beside the state so the output comes from a flop
        warm_next = (state_next != OWC_IDLE);
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            state_reg <= OWC_IDLE;
            cnt_reg   <= CNT_RESET;
            irq_reg   <= FLAG_RESET;
            warm_reg  <= FLAG_RESET;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            irq_reg   <= irq_next;
            warm_reg  <= warm_next;
        end
    end

    // Output flops mirror the init bits; kept low in warm-up by software
    always_comb begin
        uflop_next = ctrl.upper_timer_control[UTC_FLOP_BIT];
        lflop_next = ctrl.lower_timer_control[LTC_FLOP_BIT];
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            uflop_reg <= FLAG_RESET;
            lflop_reg <= FLAG_RESET;
        end else begin
            uflop_reg <= uflop_next;
            lflop_reg <= lflop_next;
        end
    end

    // All outputs straight from flops
    assign count_value     = cnt_reg;
    assign timer_match_irq = irq_reg;
    assign warm_active     = warm_reg;
    assign upper_flop_out  = uflop_reg;
    assign lower_flop_out  = lflop_reg;

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    sequence last_tick_s;
        run && src_tick && (cnt_reg == {ctrl.period_high_byte - 8'h01, 8'hFF});
    endsequence

    sequence cleared_s;
        timer_match_irq && (cnt_reg == 16'h0000);
    endsequence

    match_irq_a: assert property (last_tick_s |=> cleared_s)
        else $error("match did not clear counter and raise irq");

    slow_span_a: assert property ((timer_match_irq && $past(src_sel) == LTC_SRC_LOW)
        |-> $past(cnt_reg) == {$past(ctrl.period_high_byte) - 8'h01, 8'hFF})
        else $error("slow span not high byte times 256 ticks");

    fast_span_a: assert property ((timer_match_irq && $past(src_sel) == LTC_SRC_HIGH)
        |-> $past(cnt_reg) == {$past(ctrl.period_high_byte) - 8'h01, 8'hFF})
        else $error("fast span not high byte times 256 ticks");

    slow_source_a: assert property ((src_sel == LTC_SRC_LOW && cnt_reg != 16'h0000
        && cnt_reg != $past(cnt_reg)) |-> $past(low_rise))
        else $error("slow count moved without slow edge");

    fast_source_a: assert property ((src_sel == LTC_SRC_HIGH && cnt_reg != 16'h0000
        && cnt_reg != $past(cnt_reg)) |-> $past(high_rise))
        else $error("fast count moved without fast edge");

    warm_mode_a: assert property ((ctrl.upper_timer_control[UTC_MODE_LSB +: 3] != UTC_MODE_WARM)
        |=> (cnt_reg == 16'h0000) && !timer_match_irq)
        else $error("counter ran outside warm-up mode");

    low_ignore_a: assert property ((run && src_tick && cnt_reg[7:0] == 8'hFF
        && cnt_reg[15:8] == ctrl.period_high_byte - 8'h01) |=> timer_match_irq)
        else $error("match missed while low byte ignored");

    cascade_carry_a: assert property ((run && src_tick && !hit && cnt_reg[7:0] == 8'hFF)
        |=> cnt_reg[15:8] == $past(cnt_reg[15:8]) + 8'h01)
        else $error("carry into high byte lost");

    stop_hold_a: assert property (!ctrl.upper_timer_control[UTC_START_BIT]
        |=> !timer_match_irq ##1 (cnt_reg == 16'h0000 || $past(run)))
        else $error("stopped counter counted or raised irq");

    tick_only_a: assert property ((cnt_reg != $past(cnt_reg) && cnt_reg != 16'h0000)
        |-> $past(src_tick) && $past(run))
        else $error("count moved without a source tick");

    idle_clear_a: assert property (!warm_active |-> count_value == 16'h0000)
        else $error("idle counter not cleared");

    irq_pulse_a: assert property (timer_match_irq |=> !timer_match_irq)
        else $error("match irq longer than one cycle");
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
// Purpose: Self-checking bench for the oscillator warm-up counter.
// Assumes: Oscillator levels are driven as slow square waves, one tick per rise.
// Notes:   Short periods keep the run brief; full spans follow by scaling.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import owc_pkg::*;

    logic        clock;
    logic        rst_b;
    logic        lf;
    logic        hf;
    owc_ctrl_t   ctrl;
    logic [15:0] count_value;
    logic        irq;
    logic        warm_active;
    logic        uflop;
    logic        lflop;
    int          num_errors = 0;
    int          num_checks = 0;
    int          irq_seen = 0;

    owc_counter owc_counter_i (
        .clock           (clock),
        .rst_b           (rst_b),
        .low_freq_clock  (lf),
        .high_freq_clock (hf),
        .ctrl            (ctrl),
        .count_value     (count_value),
        .timer_match_irq (irq),
        .warm_active     (warm_active),
        .upper_flop_out  (uflop),
        .lower_flop_out  (lflop)
    );

    // Free-running system clock, 8 ns period
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // Count match pulses so none slips by between checks
    always @(posedge clock) begin
        if (irq === 1'b1) begin
            irq_seen <= irq_seen + 1;
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic setc(input logic [7:0] l, input logic [7:0] u, input logic [7:0] h, input logic [7:0] p);
        @(posedge clock);
        ctrl <= {l, u, h, p};
    endtask

    // Rising edges need a low phase between them, so each tick takes two cycles
    task automatic tick(input logic fast, input int n);
        repeat (n) begin
            @(posedge clock);
            if (fast) begin
                hf <= 1'b1;
            end else begin
                lf <= 1'b1;
            end
            @(posedge clock);
            hf <= 1'b0;
            lf <= 1'b0;
        end
        repeat (3) @(posedge clock);
        @(negedge clock);
    endtask

    task automatic end_of_test;
        $display("Checks %0d, mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Watchdog well beyond the roughly 2230 cycles the tests need
    initial begin
        #160000;
        num_errors++;
        end_of_test();
    end

    initial begin
        rst_b = 1'b0;
        lf = 1'b0;
        hf = 1'b0;
        ctrl = '0;
        repeat (12) @(posedge clock);
        rst_b <= 1'b1;
        @(negedge clock);
        chk(count_value, 16'h0000);
        chk({11'h000, irq, warm_active, uflop, lflop, 1'b0}, 16'h0000);
        // Span constants: minimum and maximum settings of both warm-ups
        chk(16'(LOW_MIN_NS / 1000), 16'h1E84);
        chk(16'((LOW_MIN_NS * 255) / 10000000), 16'h00C7);
        chk(16'(HIGH_MIN_NS / 1000), 16'h0010);
        chk(16'((HIGH_MIN_NS * 255) / 10000), 16'h0198);
        $display("reset test done");
        // Slow warm-up, low period byte nonzero but ignored
        setc(8'h43, 8'h05, 8'h01, 8'hFF);
        tick(1'b0, 2);
        chk(count_value, 16'h0000);
        setc(8'h43, 8'h0D, 8'h01, 8'hFF);
        tick(1'b0, 255);
        chk({15'h0000, warm_active}, 16'h0001);
        chk(count_value, 16'h00FF);
        tick(1'b1, 4);
        chk(count_value, 16'h00FF);
        chk(irq_seen[15:0], 16'h0000);
        tick(1'b0, 1);
        chk(count_value, 16'h0000);
        chk(irq_seen[15:0], 16'h0001);
        tick(1'b0, 1);
        chk(count_value, 16'h0001);
        $display("slow warm-up test done");
        // Stopping clears the count and blocks further matches
        setc(8'h43, 8'h05, 8'h01, 8'hFF);
        tick(1'b0, 300);
        chk(count_value, 16'h0000);
        chk({15'h0000, warm_active}, 16'h0000);
        chk(irq_seen[15:0], 16'h0001);
        // Illegal upper mode must stay stopped
        setc(8'h43, 8'h0C, 8'h01, 8'h00);
        tick(1'b0, 3);
        chk(count_value, 16'h0000);
        $display("stop test done");
        // Fast warm-up, two steps of the high period byte
        setc(8'h63, 8'h0D, 8'h02, 8'h00);
        tick(1'b1, 511);
        chk(count_value, 16'h01FF);
        tick(1'b0, 5);
        chk(count_value, 16'h01FF);
        tick(1'b1, 1);
        chk(count_value, 16'h0000);
        chk(irq_seen[15:0], 16'h0002);
        // Handler stops the timer after the fast warm-up
        setc(8'h63, 8'h05, 8'h02, 8'h00);
        tick(1'b1, 1);
        chk(count_value, 16'h0000);
        chk({15'h0000, warm_active}, 16'h0000);
        $display("fast warm-up test done");
        // Flop init bits only mirror, counter stays stopped
        setc(8'hC3, 8'h85, 8'h01, 8'h00);
        tick(1'b0, 2);
        chk({14'h0000, uflop, lflop}, 16'h0003);
        chk(count_value, 16'h0000);
        $display("flop mirror test done");
        end_of_test();
    end
endmodule
`default_nettype wire
